// ==== cgc_clock_generator.v ====
// Clock generator: base clock muxes, branch gating, PLL control and block resets
`timescale 1ns/1ps
`default_nettype none
`include "cgc_regs.vh"

// Summary of operation
// - After reset every base clock selects the internal RC oscillator.
// - The internal RC oscillator is a nominal 12 MHz source usable by the watchdog and the audio PLL.
// - Each base clock has its own independent source select.
// - A selectable base clock drives the clock-out pin and base clock 0 is the processor clock.
// - Each base clock fans out into branches from two gating units, each branch enabled separately.
// - Branches of one base clock share its timing since they gate the same enable.
// - The system PLL multiplier takes any integer from 1 to 32.
// - The system PLL output divider allows only 2, 4, 8 and 16.
// - After reset the system PLL is powered down and bypassed.
// - The audio PLL references the crystal or RC oscillator and uses a sigma-delta fractional divider.
// - The audio PLL output is 32, 64, 128, 256, 384 or 512 times the sample rate.
// - The USB PLL feeds the first high-speed USB controller and any base clock that selects it, and uses the crystal.
// - The reset generator drives an independent reset to each block.
module cgc_clock_generator #(
    parameter integer NBASE    = 4,
    parameter integer NBRANCH  = 8,
    parameter integer SETTLE   = `CGC_SETTLE_CYCLES,
    parameter integer NRESET   = 32
) (
    input  wire                   clk,
    input  wire                   sys_rst,
    input  wire [7:0]             regAddr,
    input  wire [31:0]            regWdata,
    input  wire                   regWrite,
    input  wire                   regRead,
    output reg  [31:0]            regRdata,
    input  wire                   ircTick,
    input  wire                   xtalTick,
    input  wire                   sysPllTick,
    input  wire                   audioPllTick,
    input  wire                   usbPllTick,
    output reg  [NBASE-1:0]       baseEnable,
    output reg  [NBASE*NBRANCH-1:0] branchEnable0,
    output reg  [NBASE*NBRANCH-1:0] branchEnable1,
    output reg                    processorClockEn,
    output reg                    clockOutPin,
    output reg                    watchdogClockEn,
    output reg                    usbClockEn,
    output reg                    sysPllPowerUp,
    output reg                    sysPllBypass,
    output reg  [5:0]             sysPllMul,
    output reg  [4:0]             sysPllDiv,
    output reg                    audioPllPowerUp,
    output reg                    audioPllRefRc,
    output reg  [9:0]             audioPllMultiple,
    output reg  [15:0]            audioPllFrac,
    output reg                    usbPllPowerUp,
    output reg  [NRESET-1:0]      blockReset
);
    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Shared decoders keep the divider and multiple legal sets
    // in one place; the write path and
    // the base muxes both lean on them
    // Source select to the selected source tick
    function srcTick;
        input [2:0] sel;
        input       internal_rc_oscillator, xtal, spll, apll, upll;
        begin
            case (sel)
                `CGC_SRC_XTAL: srcTick = xtal;
                `CGC_SRC_SPLL: srcTick = spll;
                `CGC_SRC_APLL: srcTick = apll;
                `CGC_SRC_UPLL: srcTick = upll;
                default:       srcTick = internal_rc_oscillator;
            endcase
        end
    endfunction

    // Legal divider: one-hot of 2, 4, 8 or 16
    function divLegal;
        input [4:0] d;
        begin
            divLegal = (d == 5'h02) || (d == 5'h04) || (d == 5'h08) || (d == 5'h10);
        end
    endfunction

    // 384 is the one multiple off a power of two
    // Legal sample-rate multiple
    function multLegal;
        input [9:0] m;
        begin
            multLegal = (m == 10'h020) || (m == 10'h040) || (m == 10'h080) ||
                        (m == 10'h100) || (m == 10'h180) || (m == 10'h200);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Three select bits per base, base 0 lowest
    reg [3*NBASE-1:0]       baseSel;
    reg [NBASE*NBRANCH-1:0] branchOn0;
    reg [NBASE*NBRANCH-1:0] branchOn1;
    reg [1:0]               clockOutSel;
    reg [31:0]              sysPllReg;
    // Write pulses that restart lock timers
    reg                     sysPllStart;
    reg                     audioPllStart;
    reg                     usbPllStart;
    // Accumulator; bit 16 is the carry
    reg [16:0]              fracAcc;
    reg                     sdCarry;
    // Lock flags of the settling timers
    wire                    sysPllLock;
    wire                    audioPllLock;
    wire                    usbPllLock;
    // Helpers; one loop index per process
    reg [NBASE-1:0]         next_baseEnable;
    reg [31:0]              next_rdata;
    integer                 i;
    integer                 j;
    // Reset select word, cut to select width
    wire [31:0]             baseSelReset = `CGC_BASESEL_RESET;

    // Register writes; illegal PLL settings are dropped so hardware never sees them
    // Start pulses last one cycle, so any PLL
    // write drops its lock until it settles
    always @(posedge clk) begin
        sysPllStart   <= 1'b0;
        audioPllStart <= 1'b0;
        usbPllStart   <= 1'b0;
        if (sys_rst) begin
            baseSel          <= baseSelReset[3*NBASE-1:0];
            branchOn0        <= `CGC_BRANCH_RESET;
            branchOn1        <= `CGC_BRANCH_RESET;
            clockOutSel      <= 2'h0;
            sysPllReg        <= `CGC_SPLL_RESET;
            sysPllMul        <= 6'h01;
            sysPllDiv        <= 5'h02;
            audioPllPowerUp  <= 1'b0;
            audioPllRefRc    <= 1'b1;
            audioPllMultiple <= 10'h100;
            audioPllFrac     <= 16'h0000;
            usbPllPowerUp    <= 1'b0;
            blockReset       <= {NRESET{1'b0}};
        end else if (regWrite) begin
            case (regAddr)
                `CGC_ADDR_BASESEL: baseSel <= regWdata[3*NBASE-1:0];
                `CGC_ADDR_BRANCH0: branchOn0 <= regWdata[NBASE*NBRANCH-1:0];
                `CGC_ADDR_BRANCH1: branchOn1 <= regWdata[NBASE*NBRANCH-1:0];
                `CGC_ADDR_CLOCK_OUT_PIN:  clockOutSel <= regWdata[1:0];
                `CGC_ADDR_SPLL: begin
                    sysPllReg   <= regWdata;
                    sysPllStart <= 1'b1;
                    if (regWdata[`CGC_SPLL_MUL_LSB+5:`CGC_SPLL_MUL_LSB] >= 6'h01 &&
                        regWdata[`CGC_SPLL_MUL_LSB+5:`CGC_SPLL_MUL_LSB] <= 6'h20) begin
                        sysPllMul <= regWdata[`CGC_SPLL_MUL_LSB+5:`CGC_SPLL_MUL_LSB];
                    end
                    if (divLegal(regWdata[`CGC_SPLL_DIV_LSB+4:`CGC_SPLL_DIV_LSB])) begin
                        sysPllDiv <= regWdata[`CGC_SPLL_DIV_LSB+4:`CGC_SPLL_DIV_LSB];
                    end
                end
                `CGC_ADDR_APLL: begin
                    audioPllPowerUp <= regWdata[`CGC_APLL_EN_BIT];
                    audioPllRefRc   <= regWdata[`CGC_APLL_REF_BIT];
                    audioPllStart   <= 1'b1;
                    if (multLegal(regWdata[`CGC_APLL_MULT_LSB+9:`CGC_APLL_MULT_LSB])) begin
                        audioPllMultiple <= regWdata[`CGC_APLL_MULT_LSB+9:`CGC_APLL_MULT_LSB];
                    end
                end
                `CGC_ADDR_APLLFRAC: begin
                    audioPllFrac  <= regWdata[15:0];
                    audioPllStart <= 1'b1;
                end
                `CGC_ADDR_UPLL: begin
                    usbPllPowerUp <= regWdata[`CGC_UPLL_EN_BIT];
                    usbPllStart   <= 1'b1;
                end
                // Active high; software releases each
                // one reset bit per block
                `CGC_ADDR_RESET: blockReset <= regWdata[NRESET-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System PLL control outputs

    // A cycle behind the register; harmless,
    // lock takes far longer to rise
    // enable and bypass straight from the register
    always @(posedge clk) begin
        if (sys_rst) begin
            sysPllPowerUp <= 1'b0;
            sysPllBypass  <= 1'b1;
        end else begin
            sysPllPowerUp <= sysPllReg[`CGC_SPLL_EN_BIT];
            sysPllBypass  <= sysPllReg[`CGC_SPLL_BYP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sigma-delta fractional step for the audio PLL

    // Carry lags the sum by one tick; a
    // first-order loop only sets the average,
    // so the extra latency does no harm
    // first-order modulator, carry only reads back in the fraction register
    always @(posedge clk) begin
        if (sys_rst || !audioPllPowerUp) begin
            fracAcc <= 17'h00000;
            sdCarry <= 1'b0;
        end else if (audioPllTick) begin
            fracAcc <= {1'b0, fracAcc[15:0]} + {1'b0, audioPllFrac};
            sdCarry <= fracAcc[16];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock timers

    // Timers stand in for analogue lock detectors
    // lock after settling; software must wait on it
    cgc_lock_timer #(.SETTLE(SETTLE)) sysLock (
        .clk     (clk),
        .sys_rst (sys_rst),
        .enable  (sysPllReg[`CGC_SPLL_EN_BIT]),
        .restart (sysPllStart),
        .locked  (sysPllLock)
    );

    // Audio PLL lock
    cgc_lock_timer #(.SETTLE(SETTLE)) audioLock (
        .clk     (clk),
        .sys_rst (sys_rst),
        .enable  (audioPllPowerUp),
        .restart (audioPllStart),
        .locked  (audioPllLock)
    );

    // USB PLL on the crystal only
    cgc_lock_timer #(.SETTLE(SETTLE)) usbLock (
        .clk     (clk),
        .sys_rst (sys_rst),
        .enable  (usbPllPowerUp),
        .restart (usbPllStart),
        .locked  (usbPllLock)
    );

    ////////////////////////////////////////////////////////////////////////
    // Base clock selection

    // USB ticks wait for lock, so a base on it
    // stays quiet; other PLLs rely on software
    // waiting for lock before selecting them
    // each base picks its own source tick
    always @* begin
        next_baseEnable = {NBASE{1'b0}};
        for (i = 0; i < NBASE; i = i + 1) begin
            next_baseEnable[i] = srcTick(baseSel[3*i +: 3], ircTick, xtalTick,
                                         sysPllTick, audioPllTick, usbPllTick & usbPllLock);
        end
    end

    // Flopped outputs keep tick glitches
    // away from the clock gates downstream
    // Enables out of flops; branches share their base flop edge
    always @(posedge clk) begin
        if (sys_rst) begin
            baseEnable       <= {NBASE{1'b0}};
            branchEnable0    <= {NBASE*NBRANCH{1'b0}};
            branchEnable1    <= {NBASE*NBRANCH{1'b0}};
            processorClockEn <= 1'b0;
            clockOutPin      <= 1'b0;
            watchdogClockEn  <= 1'b0;
            usbClockEn       <= 1'b0;
        end else begin
            baseEnable <= next_baseEnable;
            for (j = 0; j < NBASE; j = j + 1) begin
                // same base term for every branch
                branchEnable0[j*NBRANCH +: NBRANCH] <= branchOn0[j*NBRANCH +: NBRANCH] &
                                                      {NBRANCH{next_baseEnable[j]}};
                branchEnable1[j*NBRANCH +: NBRANCH] <= branchOn1[j*NBRANCH +: NBRANCH] &
                                                      {NBRANCH{next_baseEnable[j]}};
            end
            // base 0 is the processor clock
            processorClockEn <= next_baseEnable[0];
            clockOutPin      <= next_baseEnable[clockOutSel];
            watchdogClockEn  <= ircTick;
            // USB controller only from USB PLL
            usbClockEn       <= usbPllTick & usbPllLock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads

    // Read mux; unmapped addresses read zero
    always @* begin
        next_rdata = 32'h0000_0000;
        case (regAddr)
            `CGC_ADDR_CTRL:     next_rdata = `CGC_IRC_KHZ;
            `CGC_ADDR_BASESEL:  next_rdata[3*NBASE-1:0] = baseSel;
            `CGC_ADDR_BRANCH0:  next_rdata[NBASE*NBRANCH-1:0] = branchOn0;
            `CGC_ADDR_BRANCH1:  next_rdata[NBASE*NBRANCH-1:0] = branchOn1;
            // Ratio fields read back as held
            `CGC_ADDR_SPLL:     next_rdata = {11'h000, sysPllDiv, 2'h0, sysPllMul, 6'h00,
                                              sysPllReg[`CGC_SPLL_BYP_BIT], sysPllReg[`CGC_SPLL_EN_BIT]};
            `CGC_ADDR_APLL:     next_rdata = {14'h0000, audioPllMultiple, 6'h00,
                                              audioPllRefRc, audioPllPowerUp};
            `CGC_ADDR_APLLFRAC: next_rdata = {15'h0000, sdCarry, audioPllFrac};
            `CGC_ADDR_UPLL:     next_rdata[0] = usbPllPowerUp;
            `CGC_ADDR_RESET:    next_rdata[NRESET-1:0] = blockReset;
            `CGC_ADDR_STATUS:   next_rdata[2:0] = {usbPllLock, audioPllLock, sysPllLock};
            `CGC_ADDR_CLOCK_OUT_PIN:   next_rdata[1:0] = clockOutSel;
            default:            next_rdata = 32'h0000_0000;
        endcase
    end

    // Zero outside the answer cycle, so a
    // stale word never passes for a reply
    // Read data valid only in the cycle after the strobe
    always @(posedge clk) begin
        if (sys_rst || !regRead) begin
            regRdata <= 32'h0000_0000;
        end else begin
            regRdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ==== cgc_regs.vh ====
// Register map, field positions, reset values and timing counts of the clock generator
`ifndef CGC_REGS_VH
`define CGC_REGS_VH

// Register word offsets (byte addresses)
`define CGC_ADDR_CTRL        8'h00
`define CGC_ADDR_BASESEL     8'h04
`define CGC_ADDR_BRANCH0     8'h08
`define CGC_ADDR_BRANCH1     8'h0c
`define CGC_ADDR_SPLL        8'h10
`define CGC_ADDR_APLL        8'h14
`define CGC_ADDR_APLLFRAC    8'h18
`define CGC_ADDR_UPLL        8'h1c
`define CGC_ADDR_RESET       8'h20
`define CGC_ADDR_STATUS      8'h24
`define CGC_ADDR_CLOCK_OUT_PIN      8'h28

// Clock source codes, 3 bits each
`define CGC_SRC_IRC          3'h0
`define CGC_SRC_XTAL         3'h1
`define CGC_SRC_SPLL         3'h2
`define CGC_SRC_APLL         3'h3
`define CGC_SRC_UPLL         3'h4

// System PLL register fields
`define CGC_SPLL_EN_BIT      0
`define CGC_SPLL_BYP_BIT     1
`define CGC_SPLL_MUL_LSB     8
`define CGC_SPLL_DIV_LSB     16
`define CGC_SPLL_RESET       32'h0000_0002

// Audio PLL register fields
`define CGC_APLL_EN_BIT      0
`define CGC_APLL_REF_BIT     1
`define CGC_APLL_MULT_LSB    8

// USB PLL enable bit
`define CGC_UPLL_EN_BIT      0

// Status bits
`define CGC_STAT_SPLL_LOCK   0
`define CGC_STAT_APLL_LOCK   1
`define CGC_STAT_UPLL_LOCK   2

// Reset values
`define CGC_BASESEL_RESET    32'h0000_0000
`define CGC_BRANCH_RESET     32'hffff_ffff
`define CGC_RESET_RESET      32'h0000_0000

// Internal RC oscillator nominal rate, kHz
`define CGC_IRC_KHZ          12000

// PLL settling time in ns and the clock period in ns
`define CGC_SETTLE_NS        100000
`define CGC_CLK_NS           4
`define CGC_SETTLE_CYCLES    ((`CGC_SETTLE_NS + `CGC_CLK_NS - 1) / `CGC_CLK_NS)

`endif

// ==== cgc_lock_timer.v ====
// Settling counter giving one PLL's lock indication
`timescale 1ns/1ps
`default_nettype none

module cgc_lock_timer #(
    parameter integer SETTLE = 25000
) (
    input  wire clk,
    input  wire sys_rst,
    input  wire enable,
    input  wire restart,
    output reg  locked
);
    reg [31:0] count;

    // Restart on any config change, lock once settled
    always @(posedge clk) begin
        if (sys_rst || !enable || restart) begin
            count  <= 32'h0000_0000;
            locked <= 1'b0;
        end else if (count >= SETTLE - 1) begin
            locked <= 1'b1;
        end else begin
            count <= count + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// ==== cgc_source_model.sv ====
// Source tick model standing in for the oscillators and PLL cores
`timescale 1ns/1ps
`default_nettype none
module cgc_source_model (
    input  wire logic clk,
    input  wire logic sys_rst,
    output var  logic ircTick,
    output var  logic xtalTick,
    output var  logic sysPllTick,
    output var  logic audioPllTick,
    output var  logic usbPllTick
);
    logic [7:0] phase = 8'h00;

    // RC oscillator, crystal and PLL ticks
    // Patterns differ so a wrong source select shows within a few cycles
    always @(posedge clk) begin
        phase        <= sys_rst ? 8'h00 : phase + 8'h01;
        ircTick      <= phase[0];
        xtalTick     <= phase % 8'h03 == 8'h00;
        sysPllTick   <= phase[1];
        audioPllTick <= phase % 8'h05 == 8'h01;
        usbPllTick   <= phase[2] ^ phase[0];
    end
endmodule
`default_nettype wire

// ==== cgc_clock_generator_asserts.sv ====
// Concurrent checks on the clock generator ports
`timescale 1ns/1ps
`default_nettype none
module cgc_clock_generator_asserts #(
    parameter integer NBASE   = 4,
    parameter integer NBRANCH = 8
) (
    input wire logic                     clk,
    input wire logic                     sys_rst,
    input wire logic [7:0]               regAddr,
    input wire logic                     regWrite,
    input wire logic                     ircTick,
    input wire logic                     usbPllTick,
    input wire logic [NBASE-1:0]         baseEnable,
    input wire logic [NBASE*NBRANCH-1:0] branchEnable0,
    input wire logic [NBASE*NBRANCH-1:0] branchEnable1,
    input wire logic                     processorClockEn,
    input wire logic                     watchdogClockEn,
    input wire logic                     usbClockEn,
    input wire logic                     usbPllPowerUp,
    input wire logic                     sysPllPowerUp,
    input wire logic                     sysPllBypass,
    input wire logic [5:0]               sysPllMul,
    input wire logic [4:0]               sysPllDiv,
    input wire logic [9:0]               audioPllMultiple
);
    logic                     selWritten;
    wire  [NBASE*NBRANCH-1:0] anyBranch = branchEnable0 | branchEnable1;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // Until software writes the base select, every base must run from RC
    always @(posedge clk) begin
        if (sys_rst)
            selWritten <= 1'b0;
        else if (regWrite && regAddr == 8'h04)
            selWritten <= 1'b1;
    end

    rc_default_a: assert property (!$past(sys_rst) && !selWritten |-> baseEnable == {NBASE{$past(ircTick)}})
        else $error("base clock off RC");
    wdog_rc_a: assert property (!$past(sys_rst) |-> watchdogClockEn == $past(ircTick))
        else $error("watchdog clock not RC");
    proc_clock_a: assert property (processorClockEn == baseEnable[0])
        else $error("processor clock not base 0");
    spll_reset_a: assert property ($fell(sys_rst) |-> !sysPllPowerUp && sysPllBypass)
        else $error("pll not off after reset");
    spll_mul_a: assert property (sysPllMul >= 6'h01 && sysPllMul <= 6'h20)
        else $error("pll multiplier range");
    spll_div_a: assert property (sysPllDiv inside {5'h02, 5'h04, 5'h08, 5'h10})
        else $error("pll divider illegal");
    audio_mult_a: assert property (audioPllMultiple inside {10'h020, 10'h040, 10'h080, 10'h100, 10'h180, 10'h200})
        else $error("audio multiple illegal");
    usb_gate_a: assert property (usbClockEn |-> $past(usbPllTick) && $past(usbPllPowerUp, 2))
        else $error("usb clock without pll");

    // A branch may only tick when its base ticks
    for (genvar i = 0; i < NBASE; i++) begin : g_base
        branch_sync_a: assert property ((anyBranch[i*NBRANCH +: NBRANCH] & ~{NBRANCH{baseEnable[i]}}) == '0)
            else $error("branch out of step");
    end

    usb_run_c: cover property (usbClockEn);
    spll_up_c: cover property ($rose(sysPllPowerUp));
    base_sel_c: cover property (selWritten && baseEnable[1]);
endmodule

bind cgc_clock_generator cgc_clock_generator_asserts #(.NBASE(NBASE), .NBRANCH(NBRANCH)) u_asserts (
    .clk, .sys_rst, .regAddr, .regWrite, .ircTick, .usbPllTick, .baseEnable, .branchEnable0, .branchEnable1,
    .processorClockEn, .watchdogClockEn, .usbClockEn, .usbPllPowerUp, .sysPllPowerUp, .sysPllBypass,
    .sysPllMul, .sysPllDiv, .audioPllMultiple
);
`default_nettype wire

// ==== cgc_clock_generator_tb_top.sv ====
// Self-checking bench for the clock generator
`timescale 1ns/1ps
`default_nettype none
`include "cgc_regs.vh"
module cgc_clock_generator_tb_top;
    // Short settle count keeps lock waits brief
    localparam integer SETTLE = 20;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata, branchEnable0, branchEnable1, blockReset, rdVal;
    logic [3:0]  baseEnable;
    logic [4:0]  prevTick, sysPllDiv;
    logic [5:0]  sysPllMul;
    logic [9:0]  audioPllMultiple;
    logic [15:0] audioPllFrac;
    logic        ircTick, xtalTick, sysPllTick, audioPllTick, usbPllTick, processorClockEn, clockOutPin;
    logic        watchdogClockEn, usbClockEn, sysPllPowerUp, sysPllBypass, audioPllPowerUp, audioPllRefRc;
    logic        usbPllPowerUp;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;

    cgc_clock_generator #(.SETTLE(SETTLE)) dut (
        .clk, .sys_rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .ircTick, .xtalTick, .sysPllTick,
        .audioPllTick, .usbPllTick, .baseEnable, .branchEnable0, .branchEnable1, .processorClockEn, .clockOutPin,
        .watchdogClockEn, .usbClockEn, .sysPllPowerUp, .sysPllBypass, .sysPllMul, .sysPllDiv, .audioPllPowerUp,
        .audioPllRefRc, .audioPllMultiple, .audioPllFrac, .usbPllPowerUp, .blockReset
    );
    cgc_source_model src (.clk, .sys_rst, .ircTick, .xtalTick, .sysPllTick, .audioPllTick, .usbPllTick);

    initial forever #2 clk = ~clk;

    // Hang guard; the run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            $display("[FAIL] %0t timeout", $time);
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // Writes settle on every output, the two-cycle ones included
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        rdVal = regRdata;
    endtask

    task automatic doRst();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Not locked right after a write, locked within a bounded poll
    task automatic waitLock(input int b);
        rd(`CGC_ADDR_STATUS);
        check(32'(rdVal[b]), 32'h0, "early lock");
        repeat (SETTLE) begin
            rd(`CGC_ADDR_STATUS);
            if (rdVal[b] === 1'b1)
                break;
        end
        check(32'(rdVal[b]), 32'h1, "lock flag");
    endtask

    function automatic logic pick(input logic [2:0] s, input logic [4:0] t, input logic usbOn);
        return (s == 3'h4) ? (t[4] & usbOn) : t[s];
    endfunction

    // Registered outputs follow the ticks seen before each edge
    task automatic follow(input logic [11:0] sel, input logic usbOn, input logic [1:0] outSel,
                          input logic [31:0] br0, input logic [31:0] br1);
        logic [3:0]  e;
        logic [31:0] eb;
        repeat (12) begin
            prevTick = {usbPllTick, audioPllTick, sysPllTick, xtalTick, ircTick};
            @(posedge clk);
            #1;
            for (int i = 0; i < 4; i++) begin
                e[i] = pick(sel[3*i +: 3], prevTick, usbOn);
                eb[8*i +: 8] = {8{e[i]}};
            end
            check(32'(baseEnable), 32'(e), "base source");
            check(32'(processorClockEn), 32'(e[0]), "processor clock");
            check(32'(clockOutPin), 32'(e[outSel]), "clock out");
            check(32'(watchdogClockEn), 32'(prevTick[0]), "watchdog clock");
            check(branchEnable0, eb & br0, "branch unit 0");
            check(branchEnable1, eb & br1, "branch unit 1");
            check(32'(usbClockEn), 32'(prevTick[4] & usbOn), "usb clock");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check(32'({sysPllPowerUp, sysPllBypass}), 32'h1, "pll reset state");
        check(32'({sysPllMul, sysPllDiv}), 32'h22, "pll reset ratio");
        check(blockReset, 32'h0, "block reset state");
        rd(`CGC_ADDR_CTRL);
        check(rdVal, 32'h0000_2ee0, "rc rate");
        rd(`CGC_ADDR_BASESEL);
        check(rdVal, 32'h0, "base select reset");
        rd(`CGC_ADDR_STATUS);
        check(rdVal, 32'h0, "no lock at reset");
        follow(12'h000, 1'b0, 2'h0, 32'hffff_ffff, 32'hffff_ffff);
    endtask

    task automatic t_spll();
        logic [31:0] cfg [4] = '{32'h0003_0001, 32'h0010_2001, 32'h0008_2101, 32'h0004_1001};
        logic [10:0] ratio [4] = '{11'h022, 11'h410, 11'h408, 11'h204};
        for (int k = 0; k < 4; k++) begin
            wr(`CGC_ADDR_SPLL, cfg[k]);
            check(32'({sysPllMul, sysPllDiv}), 32'(ratio[k]), "pll ratio");
        end
        check(32'({sysPllPowerUp, sysPllBypass}), 32'h2, "pll running");
        waitLock(0);
    endtask

    task automatic t_select();
        wr(`CGC_ADDR_BASESEL, 32'h0000_08d1);
        wr(`CGC_ADDR_CLOCK_OUT_PIN, 32'h0000_0002);
        wr(`CGC_ADDR_BRANCH0, 32'h0f0f_00f0);
        wr(`CGC_ADDR_BRANCH1, 32'h0000_ff00);
        follow(12'h8d1, 1'b0, 2'h2, 32'h0f0f_00f0, 32'h0000_ff00);
        wr(`CGC_ADDR_UPLL, 32'h0000_0001);
        check(32'(usbPllPowerUp), 32'h1, "usb pll on");
        waitLock(2);
        wr(`CGC_ADDR_CLOCK_OUT_PIN, 32'h0000_0003);
        follow(12'h8d1, 1'b1, 2'h3, 32'h0f0f_00f0, 32'h0000_ff00);
    endtask

    task automatic t_audio();
        logic [9:0] m [6] = '{10'h020, 10'h040, 10'h080, 10'h100, 10'h180, 10'h200};
        logic       seen = 1'b0;
        foreach (m[k]) begin
            wr(`CGC_ADDR_APLL, {14'h0, m[k], 8'h01});
            check(32'(audioPllMultiple), 32'(m[k]), "audio multiple");
        end
        check(32'({audioPllPowerUp, audioPllRefRc}), 32'h2, "audio on crystal");
        wr(`CGC_ADDR_APLL, {14'h0, 10'h064, 8'h03});
        check(32'({audioPllMultiple, audioPllRefRc}), 32'h401, "audio refusal");
        wr(`CGC_ADDR_APLLFRAC, 32'h0000_beef);
        check(32'(audioPllFrac), 32'h0000_beef, "audio fraction");
        waitLock(1);
        repeat (12) begin
            rd(`CGC_ADDR_APLLFRAC);
            seen |= rdVal[16];
        end
        check(32'(seen), 32'h1, "sigma-delta carry");
    endtask

    task automatic t_resets();
        wr(`CGC_ADDR_RESET, 32'ha5a5_5a5a);
        check(blockReset, 32'ha5a5_5a5a, "block resets");
        rd(8'h3c);
        check(rdVal, 32'h0, "unmapped read");
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Second reset in mid-run, with every PLL running
    initial begin
        doRst();
        t_reset();
        t_spll();
        t_select();
        t_audio();
        t_resets();
        doRst();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
